/* prss_sequencer.sv */
// restart, sleep and power sequencing state machine of the power device
`timescale 1ns/100ps
`default_nettype none
module prss_sequencer #(
  parameter int MS_CYCLES = prss_pkg::MS_CYCLES  // cycles per millisecond
) (
  input  wire logic               clock,
  input  wire logic               reset,
  input  wire prss_pkg::prss_cfg_s cfg,           // register fields
  input  wire logic               powerOnRequest, // pulse: leave off state
  input  wire logic               powerKeyPin,    // key, low when pressed
  input  wire logic               sleepPin,       // sleep pin level
  input  wire logic               resetLineIn,    // reset line level
  input  wire logic               supplyAGood,    // supply a above good
  input  wire logic               supplyAUnder,   // supply a undervoltage
  input  wire logic               supplyBUnder,   // supply b undervoltage
  output prss_pkg::prss_rail_t    railEnable,     // rail enables
  output logic                    resetLineOut,   // open-drain data
  output logic                    resetLineOeN,   // low: line pulled low
  output logic                    registersReset, // pulse: reset registers
  output logic                    sleepMode       // sleep state status
);
  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam int PIN_KEY = 0, PIN_SLEEP = 1, PIN_RST = 2;
  localparam int PIN_GOOD = 3, PIN_UVA = 4, PIN_UVB = 5;

  logic [5:0]            pinMeta;        // first synchroniser stage
  logic [5:0]            pinSync;        // second stage, safe to use
  prss_pkg::prss_state_e state;          // current state
  prss_pkg::prss_state_e next_state;     // state for next cycle
  logic [2:0]            slot;           // current power-up slot
  logic                  restartPending; // power-down is a restart
  logic [2:0]            driveHist;      // recent own drive of line
  prss_pkg::prss_slots_t slotTable;      // selected variant table
  logic [2:0]            lastSlot;       // last slot of the variant
  logic [13:0]           longPressMs;    // selected long-press time
  logic                  inRun;          // on or sleep state
  logic                  keyHeld;        // key pressed, synced
  logic                  sleepActive;    // sleep pin at active level
  logic                  uvAny;          // either supply under
  logic                  extReset;       // other party pulls line
  logic                  keyDone;        // long press elapsed
  logic                  uvDone;         // undervoltage for 2 ms
  logic                  seqDone;        // slot, power-down or register-reset gap done
  logic                  trigOff;        // turn-off cause this cycle
  logic                  trigRestart;    // restart cause this cycle
  logic                  seqRun;         // sequence timer running
  logic                  seqDoneDly;     // elapsed gap, one cycle late

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset) begin
      pinMeta <= 6'h3F;
      pinSync <= 6'h3F;
    end else begin
      pinMeta <= {supplyBUnder, supplyAUnder, supplyAGood, resetLineIn,
                  sleepPin, powerKeyPin};
      pinSync <= pinMeta;
    end
  end

  // ----------------------------------------------------------------
  // decoded conditions
  // ----------------------------------------------------------------
  assign inRun   = (state == prss_pkg::PRSS_ON) ||
                   (state == prss_pkg::PRSS_SLEEP);
  assign keyHeld = !pinSync[PIN_KEY];
  assign sleepActive = (pinSync[PIN_SLEEP] == cfg.sleepPolarity);
  assign uvAny = pinSync[PIN_UVA] || pinSync[PIN_UVB];
  // our own release reaches the synchroniser late, so the line is only
  // trusted once it has been released for the whole history window
  // no debounce on line
  assign extReset = !pinSync[PIN_RST] && (driveHist == 3'h0);

  always_comb begin
    case (cfg.variantSel)
      2'h1: begin
        slotTable = prss_pkg::SLOTS_V2;
        lastSlot  = prss_pkg::LAST_V2;
      end
      2'h2: begin
        slotTable = prss_pkg::SLOTS_V3;
        lastSlot  = prss_pkg::LAST_V3;
      end
      default: begin  // code 3 falls back to the first variant
        slotTable = prss_pkg::SLOTS_V1;
        lastSlot  = prss_pkg::LAST_V1;
      end
    endcase
  end

  always_comb begin
    case (cfg.longPressSel)
      2'h0:    longPressMs = prss_pkg::T_LP6_MS;
      2'h1:    longPressMs = prss_pkg::T_LP8_MS;
      2'h2:    longPressMs = prss_pkg::T_LP10_MS;
      default: longPressMs = prss_pkg::T_LP12_MS;
    endcase
  end

  // rails whose slot is reached; slot 0 means stays off
  function automatic prss_pkg::prss_rail_t slotMask(
      input prss_pkg::prss_slots_t tbl, input logic [2:0] upTo);
    prss_pkg::prss_rail_t m;
    m = '0;
    for (int i = 0; i < prss_pkg::RAIL_COUNT; i++) begin
      m[i] = (tbl[i] != 3'h0) && (tbl[i] <= upTo);
    end
    return m;
  endfunction

  // ----------------------------------------------------------------
  // timers
  // ----------------------------------------------------------------
  // long-press timer
  prss_ms_timer #(.MS_CYCLES(MS_CYCLES), .MS_W(prss_pkg::MS_W)) uKey (
    .clock   (clock),
    .reset   (reset),
    .run     (inRun && keyHeld && cfg.keyRestartEnable),
    .clear   (1'b0),
    .limitMs (longPressMs),
    .done    (keyDone)
  );

  prss_ms_timer #(.MS_CYCLES(MS_CYCLES), .MS_W(prss_pkg::MS_W)) uUv (
    .clock   (clock),
    .reset   (reset),
    .run     (inRun && uvAny),
    .clear   (1'b0),
    .limitMs (prss_pkg::T_UV_MS),
    .done    (uvDone)
  );

  assign seqRun = (state == prss_pkg::PRSS_POWER_UP) ||
                  (state == prss_pkg::PRSS_POWER_DOWN) ||
                  (state == prss_pkg::PRSS_REG_RESET);

  prss_ms_timer #(.MS_CYCLES(MS_CYCLES), .MS_W(prss_pkg::MS_W)) uSeq (
    .clock   (clock),
    .reset   (reset),
    .run     (seqRun),
    .clear   (seqDoneDly),
    .limitMs (prss_pkg::T_SLOT_MS),
    .done    (seqDone)
  );

  // one-cycle restart of the gap after each elapsed interval
  always_ff @(posedge clock) begin
    if (reset) begin
      seqDoneDly <= 1'b0;
    end else begin
      seqDoneDly <= seqDone;
    end
  end

  // ----------------------------------------------------------------
  // causes; a turn-off outranks a restart seen in the same cycle
  // ----------------------------------------------------------------
  // undervoltage: off unless reset bit
  assign trigOff = inRun && ((uvDone && !cfg.uvResetEnable) ||
      cfg.shutdownRequest ||
      (cfg.sleepFunction == prss_pkg::SLEEP_FN_OFF && sleepActive));
  assign trigRestart = inRun && (keyDone || extReset ||
      (uvAny && cfg.uvResetEnable) ||
      (cfg.sleepFunction == prss_pkg::SLEEP_FN_RESTART && sleepActive));

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      prss_pkg::PRSS_OFF: begin
        if (powerOnRequest) begin
          next_state = prss_pkg::PRSS_POWER_UP;
        end
      end
      prss_pkg::PRSS_POWER_UP: begin
        if (seqDone && slot == lastSlot) begin
          next_state = prss_pkg::PRSS_ON;
        end
      end
      prss_pkg::PRSS_ON, prss_pkg::PRSS_SLEEP: begin
        if (trigOff) begin
          next_state = prss_pkg::PRSS_POWER_DOWN;
        end else if (trigRestart) begin
          if (cfg.restartMode == prss_pkg::RST_MODE_REGS &&
              pinSync[PIN_GOOD]) begin
            next_state = prss_pkg::PRSS_REG_RESET;
          end else begin
            next_state = prss_pkg::PRSS_POWER_DOWN;
          end
        end else if (cfg.sleepFunction == prss_pkg::SLEEP_FN_SLEEP &&
                     (cfg.sleepRequest || sleepActive)) begin
          next_state = prss_pkg::PRSS_SLEEP;
        end else begin
          next_state = prss_pkg::PRSS_ON;
        end
      end
      prss_pkg::PRSS_POWER_DOWN: begin
        if (seqDone) begin
          next_state = restartPending ? prss_pkg::PRSS_POWER_UP
                                      : prss_pkg::PRSS_OFF;
        end
      end
      prss_pkg::PRSS_REG_RESET: begin
        if (seqDone) begin
          next_state = prss_pkg::PRSS_ON;
        end
      end
      default: next_state = prss_pkg::PRSS_OFF;
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (reset) begin
      state <= prss_pkg::PRSS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // restart decision is taken with the supply seen at the trigger
  always_ff @(posedge clock) begin
    if (reset) begin
      restartPending <= 1'b0;
    end else if (inRun && next_state == prss_pkg::PRSS_POWER_DOWN) begin
      restartPending <= !trigOff && pinSync[PIN_GOOD];
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      slot <= 3'h0;
    end else if (next_state != prss_pkg::PRSS_POWER_UP) begin
      slot <= 3'h0;
    end else if (state != prss_pkg::PRSS_POWER_UP) begin
      slot <= 3'h1;
    end else if (seqDone && slot != lastSlot) begin
      slot <= slot + 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // rails follow the slot on the way up and drop together on the way
  // down; a register reset snaps them to the variant default set
  always_ff @(posedge clock) begin
    if (reset) begin
      railEnable <= '0;
    end else begin
      case (next_state)
        prss_pkg::PRSS_POWER_UP: begin
          // restart drops every rail before slot 1
          railEnable <= (state == prss_pkg::PRSS_POWER_DOWN) ? '0 :
              slotMask(slotTable,
              (state != prss_pkg::PRSS_POWER_UP) ? 3'h1 :
              (seqDone && slot != lastSlot) ? slot + 3'h1 : slot);
        end
        prss_pkg::PRSS_REG_RESET: begin
          railEnable <= slotMask(slotTable, lastSlot);
        end
        prss_pkg::PRSS_ON, prss_pkg::PRSS_SLEEP,
        prss_pkg::PRSS_POWER_DOWN: railEnable <= railEnable;
        default: railEnable <= '0;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      resetLineOeN <= 1'b0;
      driveHist    <= 3'h7;
    end else begin
      resetLineOeN <= (next_state == prss_pkg::PRSS_ON) ||
                      (next_state == prss_pkg::PRSS_SLEEP);
      driveHist    <= {driveHist[1:0], !resetLineOeN};
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      registersReset <= 1'b0;
      sleepMode      <= 1'b0;
      resetLineOut   <= 1'b0;
    end else begin
      registersReset <= inRun && (next_state == prss_pkg::PRSS_REG_RESET);
      sleepMode      <= (next_state == prss_pkg::PRSS_SLEEP);
      resetLineOut   <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence sDownDone;
    (state == prss_pkg::PRSS_POWER_DOWN) ##0 seqDone;
  endsequence

  AST_KEY_RESTART: assert property (
    @(posedge clock) disable iff (reset)
    keyDone && !trigOff |=> state != prss_pkg::PRSS_ON &&
                            state != prss_pkg::PRSS_SLEEP)
    else $error("long press did not leave run state");

  AST_WEAK_SUPPLY_OFF: assert property (
    @(posedge clock) disable iff (reset)
    inRun && trigRestart && !trigOff && !pinSync[PIN_GOOD] |=>
      !restartPending && state == prss_pkg::PRSS_POWER_DOWN)
    else $error("restart with weak supply did not head for off");

  AST_EXT_RESET_NOW: assert property (
    @(posedge clock) disable iff (reset)
    inRun && extReset |=> !resetLineOeN)
    else $error("external reset not taken at once");

  AST_UV_OFF: assert property (
    @(posedge clock) disable iff (reset)
    inRun && uvDone && !cfg.uvResetEnable |=>
      state == prss_pkg::PRSS_POWER_DOWN ##0 !restartPending)
    else $error("undervoltage did not turn off");

  AST_SLEEP_ENTRY: assert property (
    @(posedge clock) disable iff (reset)
    state == prss_pkg::PRSS_ON && !trigOff && !trigRestart &&
    cfg.sleepFunction == prss_pkg::SLEEP_FN_SLEEP && cfg.sleepRequest
    |=> state == prss_pkg::PRSS_SLEEP ##1 sleepMode)
    else $error("sleep request ignored");

  AST_SLOT_HOLD: assert property (
    @(posedge clock) disable iff (reset)
    state == prss_pkg::PRSS_POWER_UP && !seqDone && slot != 3'h0 &&
    $past(state) == prss_pkg::PRSS_POWER_UP
    |=> $stable(slot) && $stable(railEnable))
    else $error("slot advanced before its gap");

  AST_RELEASE_AFTER_UP: assert property (
    @(posedge clock) disable iff (reset)
    $rose(resetLineOeN) && $past(state) == prss_pkg::PRSS_POWER_UP |->
      railEnable == slotMask(slotTable, lastSlot))
    else $error("reset line released before power-up end");

  AST_DOWN_ORDER: assert property (
    @(posedge clock) disable iff (reset)
    sDownDone ##0 !restartPending |=> railEnable == '0 ##0 !resetLineOeN)
    else $error("rails not off after power-down gap");

  AST_RESTART_UP: assert property (
    @(posedge clock) disable iff (reset)
    sDownDone ##0 restartPending |=> state == prss_pkg::PRSS_POWER_UP)
    else $error("restart did not run power-up");
endmodule
`default_nettype wire

/* prss_pkg.sv */
// shared constants, types and slot tables of the restart and sleep sequencer
package prss_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ      = 40000000;          // system clock rate
  localparam int MS_CYCLES     = CLOCK_HZ / 1000;   // cycles per millisecond
  localparam int MS_W          = 14;                // width of ms counts
  localparam logic [13:0] T_SLOT_MS = 14'h0002;     // gap between slots
  localparam logic [13:0] T_UV_MS   = 14'h0002;     // undervoltage filter
  localparam logic [13:0] T_PD_MS   = 14'h0002;     // reset low before off
  localparam logic [13:0] T_LP6_MS  = 14'h1770;     // 6 s long press
  localparam logic [13:0] T_LP8_MS  = 14'h1F40;     // 8 s long press
  localparam logic [13:0] T_LP10_MS = 14'h2710;     // 10 s long press
  localparam logic [13:0] T_LP12_MS = 14'h2EE0;     // 12 s long press

  // ----------------------------------------------------------------
  // field encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SLEEP_FN_NONE    = 2'h0;   // sleep pin unused
  localparam logic [1:0] SLEEP_FN_SLEEP   = 2'h1;   // pin or bit enters sleep
  localparam logic [1:0] SLEEP_FN_OFF     = 2'h2;   // pin turns device off
  localparam logic [1:0] SLEEP_FN_RESTART = 2'h3;   // pin restarts device
  localparam logic [1:0] RST_MODE_FULL    = 2'h0;   // full restart
  localparam logic [1:0] RST_MODE_REGS    = 2'h1;   // register reset
  localparam int RAIL_COUNT = 16;                   // 5 bucks, 9 ldos, 2 sw
  localparam int SLOT_W     = 3;                    // slot number width

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [RAIL_COUNT-1:0] prss_rail_t;       // one enable per rail
  typedef logic [RAIL_COUNT-1:0][SLOT_W-1:0] prss_slots_t; // 0 = stays off

  typedef enum logic [2:0] {
    PRSS_OFF, PRSS_POWER_UP, PRSS_ON, PRSS_SLEEP, PRSS_POWER_DOWN,
    PRSS_REG_RESET
  } prss_state_e;

  typedef struct packed {
    logic       keyRestartEnable;  // long press restarts; when clear the key is ignored
    logic [1:0] longPressSel;      // 6/8/10/12 s
    logic [1:0] sleepFunction;     // sleep pin function
    logic       sleepPolarity;     // 1: sleep pin active high
    logic       sleepRequest;      // software sleep request
    logic       shutdownRequest;   // software shutdown
    logic [1:0] restartMode;       // full restart or register reset
    logic       uvResetEnable;     // undervoltage pulls reset line
    logic [1:0] variantSel;        // power-up configuration variant
  } prss_cfg_s;

  // ----------------------------------------------------------------
  // slot tables, rail 15 down to 0:
  // sw2 sw1 l9 l8 l7 l6 l5 l4 l3 l2 l1 b5 b4 b3 b2 b1
  // ----------------------------------------------------------------
  localparam prss_slots_t SLOTS_V1 = {3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h5,
    3'h5, 3'h5, 3'h2, 3'h3, 3'h2, 3'h1, 3'h5, 3'h4, 3'h2, 3'h2};
  localparam prss_slots_t SLOTS_V2 = {3'h4, 3'h0, 3'h4, 3'h4, 3'h0, 3'h0,
    3'h0, 3'h3, 3'h2, 3'h3, 3'h2, 3'h1, 3'h4, 3'h3, 3'h2, 3'h2};
  localparam prss_slots_t SLOTS_V3 = {3'h5, 3'h0, 3'h5, 3'h5, 3'h5, 3'h3,
    3'h0, 3'h3, 3'h2, 3'h3, 3'h2, 3'h1, 3'h5, 3'h3, 3'h4, 3'h2};
  localparam logic [2:0] LAST_V1 = 3'h5;            // last slot, variant 1
  localparam logic [2:0] LAST_V2 = 3'h4;            // last slot, variant 2
  localparam logic [2:0] LAST_V3 = 3'h5;            // last slot, variant 3

endpackage

/* prss_ms_timer.sv */
// millisecond timer with its own prescaler, restarted whenever idle
`timescale 1ns/100ps
`default_nettype none
module prss_ms_timer #(
  parameter int MS_CYCLES = 40000,  // clock cycles per millisecond
  parameter int MS_W      = 14      // width of the millisecond count
) (
  input  wire logic            clock,
  input  wire logic            reset,
  input  wire logic            run,      // count while high
  input  wire logic            clear,    // restart the interval
  input  wire logic [MS_W-1:0] limitMs,  // interval in ms
  output logic                 done      // level: interval elapsed
);
  localparam int PRE_W = $clog2(MS_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(MS_CYCLES - 1);

  logic [PRE_W-1:0] prescale;  // cycles inside the current ms
  logic [MS_W-1:0]  msCount;   // whole ms elapsed

  // ----------------------------------------------------------------
  // prescaler and ms count; restarting the prescaler keeps the
  // first ms full length, so intervals never come out short
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (reset || !run || clear) begin
      prescale <= '0;
      msCount  <= '0;
    end else if (msCount != limitMs) begin
      if (prescale == PRE_LAST) begin
        prescale <= '0;
        msCount  <= msCount + MS_W'(1);
      end else begin
        prescale <= prescale + PRE_W'(1);
      end
    end
  end

  // saturates at the limit until run falls or clear comes
  assign done = run && !clear && (msCount == limitMs);
endmodule
`default_nettype wire

/* prss_host_model.sv */
// host processor model sitting on the open-drain reset line
`timescale 1ns/100ps
`default_nettype none
module prss_host_model (
  input  wire logic devOut,   // device data, always low
  input  wire logic devOeN,   // low: device pulls the line
  input  wire logic hostPull, // host pulls the line low
  output logic      lineLvl   // resolved line level
);
  // pull-up holds the line high unless a party pulls it low
  assign lineLvl = !((!devOeN && !devOut) || hostPull);
endmodule
`default_nettype wire

/* tb_top.sv */
// self-checking bench of the restart and sleep sequencer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int M  = 2;      // short millisecond keeps long presses cheap
  localparam int SL = 2 * M + 2;  // slot gap plus timer restart cycles
  logic                clock = 1'b0;
  logic                reset = 1'b1;
  prss_pkg::prss_cfg_s cfg = '0;
  logic                powerOnRequest = 1'b0;
  logic                powerKeyPin = 1'b1;
  logic                sleepPin = 1'b1;
  logic                hostPull = 1'b0;
  logic                supplyAGood = 1'b1;
  logic                supplyAUnder = 1'b0;
  logic                supplyBUnder = 1'b0;
  prss_pkg::prss_rail_t railEnable;
  logic                resetLineOut, resetLineOeN, registersReset;
  logic                sleepMode, lineLvl;
  int                  error_cnt = 0;
  int                  n_tests = 0;
  int                  cyc = 0;
  int                  lastSlot [3] = '{5, 4, 5};
  // cumulative rail masks per slot for each variant
  logic [15:0] masks [3][5] = '{
    '{16'h0010, 16'h00B3, 16'h00F3, 16'h00F7, 16'h07FF},
    '{16'h0010, 16'h00B3, 16'h01F7, 16'hB1FF, 16'h0000},
    '{16'h0010, 16'h00B1, 16'h05F5, 16'h05F7, 16'hBDFF}};

  prss_sequencer #(.MS_CYCLES(M)) i_dut (
    .clock(clock), .reset(reset), .cfg(cfg),
    .powerOnRequest(powerOnRequest), .powerKeyPin(powerKeyPin),
    .sleepPin(sleepPin), .resetLineIn(lineLvl),
    .supplyAGood(supplyAGood), .supplyAUnder(supplyAUnder),
    .supplyBUnder(supplyBUnder), .railEnable(railEnable),
    .resetLineOut(resetLineOut), .resetLineOeN(resetLineOeN),
    .registersReset(registersReset), .sleepMode(sleepMode));

  prss_host_model i_host (.devOut(resetLineOut), .devOeN(resetLineOeN),
    .hostPull(hostPull), .lineLvl(lineLvl));

  always #12.5 clock = ~clock;

  // hang guard: the long presses dominate the run
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // inputs always change 1 ns after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic waitOe(input logic v, input int lim);
    for (int n = 0; n < lim && resetLineOeN !== v; n++) tick(1);
  endtask

  // slot walk; samples land inside each slot, clear of its edges
  task automatic seq(input int v);
    tick(3);
    for (int s = 0; s < lastSlot[v]; s++) begin
      chk(railEnable, masks[v][s]);
      chk(16'(resetLineOeN), 16'h0000);
      tick(SL);
    end
    waitOe(1'b1, SL);
    chk(16'(resetLineOeN), 16'h0001);
  endtask

  task automatic powerUp(input int v);
    cfg.variantSel = 2'(v);
    powerOnRequest = 1'b1;
    tick(1);
    powerOnRequest = 1'b0;
    seq(v);
  endtask

  // line pulled first, rails held 2 ms, then all off together
  task automatic down();
    waitOe(1'b0, 16);
    chk(16'(resetLineOeN), 16'h0000);
    tick(SL / 2);
    chk(railEnable, masks[0][4]);
    for (int n = 0; n < SL + 2 && railEnable !== '0; n++) tick(1);
    chk(railEnable, 16'h0000);
  endtask

  initial begin
    tick(12);
    reset = 1'b0;
    tick(3);
    for (int v = 0; v < 3; v++) begin
      powerUp(v);
      cfg.shutdownRequest = 1'b1;
      waitOe(1'b0, 8);
      chk(16'(resetLineOeN), 16'h0000);
      tick(SL + 4);
      chk(railEnable, 16'h0000);
      cfg.shutdownRequest = 1'b0;
    end
    powerUp(0);
    hostPull = 1'b1;
    tick(2);
    hostPull = 1'b0;
    down();
    seq(0);
    cfg.restartMode = prss_pkg::RST_MODE_REGS;
    hostPull = 1'b1;
    tick(2);
    hostPull = 1'b0;
    for (int n = 0; n < 8 && registersReset !== 1'b1; n++) tick(1);
    chk(16'(registersReset), 16'h0001);
    chk(railEnable, masks[0][4]);
    waitOe(1'b1, SL + 6);
    chk(16'(resetLineOeN), 16'h0001);
    cfg.restartMode = prss_pkg::RST_MODE_FULL;
    cfg.sleepFunction = prss_pkg::SLEEP_FN_SLEEP;
    cfg.sleepRequest = 1'b1;
    tick(2);
    chk(16'(sleepMode), 16'h0001);
    chk(railEnable, masks[0][4]);
    cfg.sleepRequest = 1'b0;
    tick(2);
    chk(16'(sleepMode), 16'h0000);
    sleepPin = 1'b0;
    tick(5);
    chk(16'(sleepMode), 16'h0001);
    sleepPin = 1'b1;
    tick(5);
    chk(16'(sleepMode), 16'h0000);
    cfg.sleepFunction = prss_pkg::SLEEP_FN_RESTART;
    cfg.sleepPolarity = 1'b1;
    down();
    sleepPin = 1'b0;
    seq(0);
    supplyAGood = 1'b0;
    sleepPin = 1'b1;
    down();
    sleepPin = 1'b0;
    tick(20);
    chk(railEnable, 16'h0000);
    chk(16'(resetLineOeN), 16'h0000);
    supplyAGood = 1'b1;
    cfg.sleepFunction = prss_pkg::SLEEP_FN_NONE;
    powerUp(0);
    // restart mode stays full while undervoltage restart is on
    cfg.uvResetEnable = 1'b1;
    supplyBUnder = 1'b1;
    tick(2);
    supplyBUnder = 1'b0;
    down();
    cfg.uvResetEnable = 1'b0;
    seq(0);
    supplyAUnder = 1'b1;
    tick(2);
    supplyAUnder = 1'b0;
    tick(10);
    chk(16'(resetLineOeN), 16'h0001);
    supplyAUnder = 1'b1;
    down();
    tick(10);
    chk(railEnable, 16'h0000);
    supplyAUnder = 1'b0;
    powerUp(0);
    cfg.keyRestartEnable = 1'b1;
    for (int s = 0; s < 4; s++) begin
      cfg.longPressSel = 2'(s);
      powerKeyPin = 1'b0;
      tick((6000 + 2000 * s) * M - 8);
      chk(16'(resetLineOeN), 16'h0001);
      down();
      powerKeyPin = 1'b1;
      seq(0);
    end
    results();
  end
endmodule
`default_nettype wire
